/* hdl/jog_consts.svh */
// named constants of the jog axis
// assumes a 10 MHz ref_clk and byte addresses on a 32-bit register bus
`ifndef JOG_CONSTS_SVH
`define JOG_CONSTS_SVH
// ----------------------------------------
// timing
// ----------------------------------------
`define CLK_PERIOD_NS 100
`define NS_PER_MS 1000000
`define CYC_PER_MS (`NS_PER_MS / `CLK_PERIOD_NS)
`define TRIG_LAT_US 15
`define TRIG_LAT_CYC ((`TRIG_LAT_US * 1000) / `CLK_PERIOD_NS)
`define TRIG_LAT_USED 1
// ----------------------------------------
// register offsets
// ----------------------------------------
`define OFS_CTRL 8'h00
`define OFS_START_SPD 8'h04
`define OFS_TARGET_SPD 8'h08
`define OFS_RAMP_MS 8'h0c
`define OFS_POS_CMD 8'h10
`define OFS_CMD 8'h14
`define OFS_STATUS 8'h18
`define OFS_COUNT 8'h1c
`define OFS_BASE_WORD 8'h20
// ----------------------------------------
// fields and reset values
// ----------------------------------------
`define CTRL_RST 32'h0200_0000
`define CTRL_LIM_INV 7
`define CTRL_ABS 8
`define BASE_WORD_RST 32'h0000_000a
`define MAX_SPD 32'h003d_0900
`define MAX_RAMP_MS 32'h0000_7fff
`define CMD_START 0
`define CMD_TRIG 1
`define CMD_FSTOP 2
`define CMD_DSTOP 3
`define CMD_PULSER 4
`define CMD_ERRCLR 5
`define CMD_W 6
`define ST_BUSY 0
`define ST_DONE 1
`define ST_SET_ERR 2
`define ST_LIM_ERR 3
`define ST_DIR 4
`define ST_TRIGGERED 5
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10
`endif

/* hdl/jog_pkg.sv */
// types shared by the jog positioning axis
// assumes nothing beyond a SystemVerilog elaborator
package jog_pkg;
  typedef enum logic [1:0]
  {
    ST_IDLE = 2'b00,
    ST_JOG = 2'b01,
    ST_POS = 2'b10,
    ST_HALT = 2'b11
  } axis_state_e;
  typedef logic [31:0] word_t;
endpackage : jog_pkg

/* hdl/ramp_if.sv */
// carrier between the axis sequencer and its pulse generator
// assumes both ends run on the same ref_clk
`timescale 1ns/1ps
interface ramp_if #(parameter int SPD_W = 22);
  logic run;
  logic decel;
  logic [SPD_W-1:0] start_spd;
  logic [SPD_W-1:0] target_spd;
  logic [31:0] ramp_cyc;
  logic step;
  logic at_floor;
  logic [SPD_W-1:0] speed;
  modport ctl (output run, decel, start_spd, target_spd, ramp_cyc, input step, at_floor, speed);
  modport gen (input run, decel, start_spd, target_spd, ramp_cyc, output step, at_floor, speed);
endinterface : ramp_if

/* hdl/pulse_gen.sv */
// linear-ramp pulse rate generator: one step pulse per output pulse
// assumes target above start speed while run is high
`timescale 1ns/1ps
`include "jog_consts.svh"
module pulse_gen
  import jog_pkg::*;
#(
  parameter int CLK_HZ = 10_000_000,
  parameter int SPD_W = 22,
  parameter int ACC_W = 25
)
(
  input wire logic ref_clk,
  input wire logic reset,
  ramp_if.gen rp
);
  // ----------------------------------------
  // elaboration check
  // ----------------------------------------
  if ((64'd1 << ACC_W) <= 64'(2 * CLK_HZ))
  begin : bad_acc_w
    $error("phase accumulator too narrow");
  end

  localparam logic [ACC_W-1:0] WRAP = ACC_W'(CLK_HZ);
  logic [ACC_W-1:0] phase_r;
  logic [ACC_W-1:0] phase_sum;
  logic step_r;
  logic [SPD_W-1:0] speed_r;
  logic [SPD_W-1:0] goal;
  logic [32:0] err_r;
  logic [32:0] err_sum;

  // ----------------------------------------
  // phase accumulator
  // ----------------------------------------
  assign phase_sum = phase_r + ACC_W'(speed_r);
  always_ff @(posedge ref_clk)
  begin
    if (reset || !rp.run)
    begin
      phase_r <= '0;
      step_r <= 1'b0;
    end
    else if (phase_sum >= WRAP)
    begin
      phase_r <= phase_sum - WRAP;
      step_r <= 1'b1;
    end
    else
    begin
      phase_r <= phase_sum;
      step_r <= 1'b0;
    end
  end

  // ----------------------------------------
  // speed ramp
  // ----------------------------------------
  // slope capped at one pps per clock unless ramp_cyc is zero, which jumps straight to goal; steeper ramps simply take longer
  assign goal = rp.decel ? rp.start_spd : rp.target_spd;
  assign err_sum = err_r + 33'(rp.target_spd - rp.start_spd);
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      speed_r <= '0;
      err_r <= '0;
    end
    else if (!rp.run)
    begin
      speed_r <= rp.start_spd;
      err_r <= '0;
    end
    else if (rp.ramp_cyc == 32'h0000_0000)
    begin
      speed_r <= goal;
    end
    else if (speed_r == goal)
    begin
      err_r <= '0;
    end
    else if (err_sum >= {1'b0, rp.ramp_cyc})
    begin
      err_r <= err_sum - {1'b0, rp.ramp_cyc};
      speed_r <= (speed_r < goal) ? speed_r + 1'b1 : speed_r - 1'b1;
    end
    else
    begin
      err_r <= err_sum;
    end
  end

  assign rp.step = step_r;
  assign rp.speed = speed_r;
  assign rp.at_floor = speed_r <= rp.start_spd;
endmodule : pulse_gen

/* hdl/jog_positioning_pulse_axis.sv */
// one pulse-output axis in jog positioning mode behind an axi4-lite register slave
// assumes pins synchronous to ref_clk and a cw/ccw motor driver on the outputs
//
// The implementer's own choices: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`include "jog_consts.svh"
// Overview of operation
// R1: timing input triggers the relative move while jogging.
// R2: start while busy is ignored.
// R3: busy rises after start, falls when output ends.
// R4: busy refuses other starts; stops still accepted.
// R5: one busy flag for moving modes, not pulser input.
// R6: done sets at output end, holds until next start.
// R7: one done flag for all modes incl. pulser input.
// R8: increment, positive command moves plus.
// R9: increment, negative command moves minus.
// R10: absolute method gives set value error, no move.
// R11: target 1..4,000,000 above startup; startup 0..4,000,000.
// R12: ramp time 0..32,767 ms.
// R13: position command is signed 32-bit.
// R14: control code option bits clear: cw/ccw, increment.
// R15: limit bit of control code inverts over-limit logic.
// R16: flag numbers relative to starting word, default ten.
// R17: counting starts within 15 us of timing input.
// R18: no timing input: pulses continue at jog speed.
// R19: out-of-range parameter: set value error, no start.
// R20: active over-limit either way blocks start with error.
// R21: after commanded count: decelerate, stop, set done.
module jog_positioning_pulse_axis
  import jog_pkg::*;
#(
  parameter int CLK_HZ = 10_000_000,
  parameter int SPD_W = 22
)
(
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic timing_in,
  input wire logic limit_pos_in,
  input wire logic limit_neg_in,
  output logic cw_out,
  output logic ccw_out,
  output logic busy_out,
  output logic done_out
);
  // ----------------------------------------
  // elaboration check
  // ----------------------------------------
  if (64'(CLK_HZ) <= 64'(`MAX_SPD) || (64'd1 << SPD_W) <= 64'(`MAX_SPD) || `TRIG_LAT_USED > `TRIG_LAT_CYC)
  begin : bad_cfg
    $error("clock or speed width cannot serve the speed range");
  end

  function automatic word_t strb_merge(input word_t old, input word_t data, input logic [3:0] strb);
    word_t res;
    res = old;
    for (int i = 0; i < 4; i++)
      if (strb[i])
        res[i*8 +: 8] = data[i*8 +: 8];
    return res;
  endfunction : strb_merge

  function automatic logic addr_ok(input logic [7:0] a);
    return a == `OFS_CTRL || a == `OFS_START_SPD || a == `OFS_TARGET_SPD || a == `OFS_RAMP_MS
      || a == `OFS_POS_CMD || a == `OFS_CMD || a == `OFS_STATUS || a == `OFS_COUNT || a == `OFS_BASE_WORD;
  endfunction : addr_ok

  axis_state_e state_r;
  word_t ctrl_r, start_spd_r, target_spd_r, ramp_ms_r, pos_cmd_r, base_word_r;
  word_t mag_r, count_r, acc_pulses_r, cnt_nxt, rd_word;
  logic [`CMD_W-1:0] cmd_r;
  logic aw_full_r, w_full_r, wr_fire;
  logic [7:0] aw_addr_r;
  word_t w_data_r;
  logic [3:0] w_strb_r;
  logic busy_r, done_r, set_err_r, lim_err_r, dir_r, decel_r, trig_seen_r;
  logic timing_r, lim_pos_r, lim_neg_r;
  logic lim_pos_act, lim_neg_act, dir_lim, running, param_bad, start_ok, launch, pulser_ok;
  logic reached, near_end, fin, set_err_evt, lim_err_evt;

  ramp_if #(.SPD_W(SPD_W)) rp ();

  pulse_gen #(.CLK_HZ(CLK_HZ), .SPD_W(SPD_W), .ACC_W(25)) u_gen
  (
    .ref_clk(ref_clk),
    .reset(reset),
    .rp(rp.gen)
  );

  // ----------------------------------------
  // axi4-lite write channel
  // ----------------------------------------
  assign wr_fire = aw_full_r && w_full_r && !s_axi_bvalid;
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      aw_full_r <= 1'b0;
      s_axi_awready <= 1'b1;
      aw_addr_r <= '0;
      w_full_r <= 1'b0;
      s_axi_wready <= 1'b1;
      w_data_r <= '0;
      w_strb_r <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_full_r <= 1'b1;
        s_axi_awready <= 1'b0;
        aw_addr_r <= s_axi_awaddr;
      end
      else if (wr_fire)
      begin
        aw_full_r <= 1'b0;
        s_axi_awready <= 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_full_r <= 1'b1;
        s_axi_wready <= 1'b0;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end
      else if (wr_fire)
      begin
        w_full_r <= 1'b0;
        s_axi_wready <= 1'b1;
      end
      if (wr_fire)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= addr_ok(aw_addr_r) ? `RESP_OKAY : `RESP_SLVERR;
      end
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // ----------------------------------------
  // parameter registers and command pulses
  // ----------------------------------------
  // unit memory is shared by all modes, so it is never rewritten by the axis itself
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      ctrl_r <= `CTRL_RST; // [R14]
      start_spd_r <= '0;
      target_spd_r <= '0;
      ramp_ms_r <= '0;
      pos_cmd_r <= '0;
      base_word_r <= `BASE_WORD_RST; // [R16]
      cmd_r <= '0;
    end
    else
    begin
      cmd_r <= '0;
      if (wr_fire)
        case (aw_addr_r)
          `OFS_CTRL: ctrl_r <= strb_merge(ctrl_r, w_data_r, w_strb_r);
          `OFS_START_SPD: start_spd_r <= strb_merge(start_spd_r, w_data_r, w_strb_r);
          `OFS_TARGET_SPD: target_spd_r <= strb_merge(target_spd_r, w_data_r, w_strb_r);
          `OFS_RAMP_MS: ramp_ms_r <= strb_merge(ramp_ms_r, w_data_r, w_strb_r);
          `OFS_POS_CMD: pos_cmd_r <= strb_merge(pos_cmd_r, w_data_r, w_strb_r); // [R13]
          `OFS_BASE_WORD: base_word_r <= strb_merge(base_word_r, w_data_r, w_strb_r); // [R16]
          `OFS_CMD: cmd_r <= w_strb_r[0] ? w_data_r[`CMD_W-1:0] : '0;
          default: cmd_r <= '0;
        endcase
    end
  end

  // ----------------------------------------
  // axi4-lite read channel
  // ----------------------------------------
  always_comb
  begin
    rd_word = '0;
    case (s_axi_araddr)
      `OFS_CTRL: rd_word = ctrl_r;
      `OFS_START_SPD: rd_word = start_spd_r;
      `OFS_TARGET_SPD: rd_word = target_spd_r;
      `OFS_RAMP_MS: rd_word = ramp_ms_r;
      `OFS_POS_CMD: rd_word = pos_cmd_r;
      `OFS_COUNT: rd_word = count_r;
      `OFS_BASE_WORD: rd_word = base_word_r;
      `OFS_STATUS:
      begin
        rd_word[`ST_BUSY] = busy_r;
        rd_word[`ST_DONE] = done_r;
        rd_word[`ST_SET_ERR] = set_err_r;
        rd_word[`ST_LIM_ERR] = lim_err_r;
        rd_word[`ST_DIR] = dir_r;
        rd_word[`ST_TRIGGERED] = trig_seen_r;
      end
      default: rd_word = '0;
    endcase
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= `RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word;
      s_axi_rresp <= addr_ok(s_axi_araddr) ? `RESP_OKAY : `RESP_SLVERR;
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // ----------------------------------------
  // pins and start checks
  // ----------------------------------------
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      timing_r <= 1'b0;
      lim_pos_r <= 1'b0;
      lim_neg_r <= 1'b0;
    end
    else
    begin
      timing_r <= timing_in;
      lim_pos_r <= limit_pos_in;
      lim_neg_r <= limit_neg_in;
    end
  end

  // default logic: an open (low) limit input counts as active
  assign lim_pos_act = ctrl_r[`CTRL_LIM_INV] ? lim_pos_r : !lim_pos_r; // [R15]
  assign lim_neg_act = ctrl_r[`CTRL_LIM_INV] ? lim_neg_r : !lim_neg_r; // [R15]
  assign param_bad = target_spd_r == '0 || target_spd_r > `MAX_SPD || start_spd_r > `MAX_SPD // [R11] [R19]
    || target_spd_r <= start_spd_r || ramp_ms_r > `MAX_RAMP_MS; // [R11] [R12] [R19]
  assign running = state_r != ST_IDLE;
  assign start_ok = cmd_r[`CMD_START] && !busy_r; // [R2]
  assign pulser_ok = cmd_r[`CMD_PULSER] && !busy_r; // [R4] [R5]
  assign set_err_evt = start_ok && (param_bad || ctrl_r[`CTRL_ABS]); // [R10] [R19]
  assign lim_err_evt = (start_ok && (lim_pos_act || lim_neg_act)) || (running && dir_lim); // [R20]
  assign launch = start_ok && !param_bad && !ctrl_r[`CTRL_ABS] && !lim_pos_act && !lim_neg_act; // [R10] [R20]
  assign dir_lim = dir_r ? lim_neg_act : lim_pos_act;

  // ----------------------------------------
  // pulse counting
  // ----------------------------------------
  assign cnt_nxt = count_r + {31'h0000_0000, rp.step};
  assign reached = state_r == ST_POS && cnt_nxt >= mag_r; // [R21]
  assign near_end = state_r == ST_POS && (mag_r - cnt_nxt) <= acc_pulses_r; // [R21]

  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      count_r <= '0;
      acc_pulses_r <= '0;
    end
    else if (launch)
    begin
      count_r <= '0;
      acc_pulses_r <= '0;
    end
    else
    begin
      if (state_r == ST_POS)
        count_r <= cnt_nxt; // [R17]
      // pulses spent accelerating mirror those needed to slow down again
      if (running && !rp.decel && rp.step && rp.speed < target_spd_r[SPD_W-1:0])
        acc_pulses_r <= acc_pulses_r + 32'h0000_0001;
    end
  end

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  assign fin = running && (cmd_r[`CMD_FSTOP] || dir_lim || reached || (state_r == ST_HALT && rp.at_floor));

  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      state_r <= ST_IDLE;
      busy_r <= 1'b0;
      dir_r <= 1'b0;
      mag_r <= '0;
      decel_r <= 1'b0;
      trig_seen_r <= 1'b0;
    end
    else if (fin)
    begin
      state_r <= ST_IDLE;
      busy_r <= 1'b0; // [R3] [R5]
      decel_r <= 1'b0;
    end
    else
    begin
      unique case (state_r)
        ST_IDLE:
          if (launch)
          begin
            state_r <= ST_JOG;
            busy_r <= 1'b1; // [R3] [R5]
            dir_r <= pos_cmd_r[31]; // [R8] [R9]
            mag_r <= pos_cmd_r[31] ? 32'h0000_0000 - pos_cmd_r : pos_cmd_r; // [R13]
            trig_seen_r <= 1'b0;
          end
        ST_JOG:
          if (cmd_r[`CMD_DSTOP])
            state_r <= ST_HALT; // [R4]
          else if (timing_r || cmd_r[`CMD_TRIG])
          begin
            state_r <= ST_POS; // [R1] [R17] [R18]
            trig_seen_r <= 1'b1;
          end
        ST_POS:
          if (cmd_r[`CMD_DSTOP])
            state_r <= ST_HALT; // [R4]
          else if (near_end)
            decel_r <= 1'b1; // [R21]
        ST_HALT: state_r <= ST_HALT;
      endcase
    end
  end

  // ----------------------------------------
  // flags and error latches
  // ----------------------------------------
  // an event in the same cycle as a clear keeps its flag set
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      done_r <= 1'b0;
      set_err_r <= 1'b0;
      lim_err_r <= 1'b0;
    end
    else
    begin
      if (fin)
        done_r <= 1'b1; // [R6] [R21]
      else if (launch || pulser_ok)
        done_r <= 1'b0; // [R6] [R7]
      set_err_r <= set_err_evt || (set_err_r && !cmd_r[`CMD_ERRCLR]);
      lim_err_r <= lim_err_evt || (lim_err_r && !cmd_r[`CMD_ERRCLR]);
    end
  end

  assign rp.run = running;
  assign rp.decel = decel_r || state_r == ST_HALT;
  assign rp.start_spd = start_spd_r[SPD_W-1:0];
  assign rp.target_spd = target_spd_r[SPD_W-1:0];
  assign rp.ramp_cyc = 32'(ramp_ms_r * `CYC_PER_MS);

  // ----------------------------------------
  // pin outputs
  // ----------------------------------------
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      cw_out <= 1'b0;
      ccw_out <= 1'b0;
      busy_out <= 1'b0;
      done_out <= 1'b0;
    end
    else
    begin
      cw_out <= running && rp.step && !dir_r; // [R8] [R14]
      ccw_out <= running && rp.step && dir_r; // [R9] [R14]
      busy_out <= busy_r;
      done_out <= done_r;
    end
  end
endmodule : jog_positioning_pulse_axis

/* tb/jog_asserts.sv */
// port-level checks of the jog positioning axis
// assumes binding onto jog_positioning_pulse_axis, one clock domain
`timescale 1ns/1ps
module jog_asserts
  import jog_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic cw_out,
  input wire logic ccw_out,
  input wire logic busy_out,
  input wire logic done_out
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  // ----------------------------------------
  // helper: recent register write
  // ----------------------------------------
  // busy only rises and done only falls after a write, so four cycles of history suffice
  logic [3:0] bv_r;
  logic wr_recent;
  always_ff @(posedge ref_clk)
  begin
    bv_r <= reset ? 4'h0 : {bv_r[2:0], s_axi_bvalid};
  end
  assign wr_recent = |bv_r;
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  a_pulse_one_dir: assert property (!(cw_out && ccw_out))
    else $error("cw and ccw pulse together");
  a_idle_no_pulse: assert property (!busy_out [*4] |-> !cw_out && !ccw_out)
    else $error("pulse while not busy");
  a_busy_end_done: assert property ($fell(busy_out) |-> done_out)
    else $error("busy ended without done");
  a_busy_done_apart: assert property (busy_out |-> !done_out)
    else $error("done still set while busy");
  a_busy_from_cmd: assert property ($rose(busy_out) |-> wr_recent)
    else $error("busy rose without a command");
  a_done_clr_cmd: assert property ($fell(done_out) |-> wr_recent)
    else $error("done dropped without a new operation");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response not held");
  a_bvalid_soon: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##[1:2] s_axi_bvalid)
    else $error("write response late");
  a_rvalid_next: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  a_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
    else $error("read data dropped");
  c_busy: cover property ($rose(busy_out));
  c_done: cover property ($rose(done_out));
  c_slverr: cover property (s_axi_bvalid && s_axi_bresp == 2'b10);
endmodule : jog_asserts

bind jog_positioning_pulse_axis jog_asserts chk (.ref_clk, .reset, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .cw_out, .ccw_out, .busy_out, .done_out);

/* tb/motor_drv_model.sv */
// cw/ccw motor driver: counts pulses per direction
// assumes one-cycle pulses synchronous to ref_clk
`timescale 1ns/1ps
module motor_drv_model
(
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic cw_pulse,
  input wire logic ccw_pulse,
  output int cw_count,
  output int ccw_count
);
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      cw_count <= 0;
      ccw_count <= 0;
    end
    else
    begin
      cw_count <= cw_count + int'(cw_pulse);
      ccw_count <= ccw_count + int'(ccw_pulse);
    end
  end
endmodule : motor_drv_model

/* tb/tb_top.sv */
// self-checking bench of the jog positioning axis
// assumes the axis register map and a cw/ccw driver model
`timescale 1ns/1ps
`include "jog_consts.svh"
module tb_top
  import jog_pkg::*;
;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  word_t s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic timing_in = 1'b0, limit_pos_in = 1'b1, limit_neg_in = 1'b1;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic cw_out, ccw_out, busy_out, done_out;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  int err_count = 0, samples_checked = 0, cw_count, ccw_count, c0, c1, mag;
  word_t lfsr = 32'h5f53e29e;
  word_t bad [5][4] = '{'{32'h0200_0180, 32'h182b8, 32'h186a0, 32'h0}, '{32'h0200_0080, 32'h0, 32'h0, 32'h0},
    '{32'h0200_0080, 32'h186a0, 32'h186a0, 32'h0}, '{32'h0200_0080, 32'h0, 32'h3d0901, 32'h0},
    '{32'h0200_0080, 32'h182b8, 32'h186a0, 32'h8000}};
  always #50 ref_clk = ~ref_clk;
  jog_positioning_pulse_axis uut (.ref_clk, .reset, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .timing_in, .limit_pos_in, .limit_neg_in, .cw_out, .ccw_out, .busy_out, .done_out);
  motor_drv_model drv (.ref_clk, .reset, .cw_pulse(cw_out), .ccw_pulse(ccw_out), .cw_count, .ccw_count);
  // ----------------------------------------
  // compare and bus tasks
  // ----------------------------------------
  task automatic check_reg(input word_t got, input word_t exp, input word_t mask);
    samples_checked++;
    if ((got & mask) !== (exp & mask))
    begin
      err_count++;
      $display("unexpected at %0t: word %h, want %h", $time, got, exp);
    end
  endtask : check_reg
  task automatic check_bit(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp)
    begin
      err_count++;
      $display("unexpected at %0t: flag %b, want %b", $time, got, exp);
    end
  endtask : check_bit
  task automatic wr(input logic [7:0] a, input word_t d, input logic [1:0] er = `RESP_OKAY);
    int n;
    n = 0;
    @(posedge ref_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge ref_clk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end
    while (s_axi_bvalid !== 1'b1 && n < 1000);
    s_axi_bready <= 1'b0;
    check_reg(32'(s_axi_bresp), 32'(er), 32'h3);
  endtask : wr
  task automatic rchk(input logic [7:0] a, input word_t exp, input word_t mask, input logic [1:0] er = `RESP_OKAY);
    int n;
    n = 0;
    @(posedge ref_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge ref_clk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end
    while (s_axi_rvalid !== 1'b1 && n < 1000);
    s_axi_rready <= 1'b0;
    check_reg(s_axi_rdata, exp, mask);
    check_reg(32'(s_axi_rresp), 32'(er), 32'h3);
  endtask : rchk
  task automatic cmd(input int b);
    wr(`OFS_CMD, word_t'(1) << b);
    repeat (4) @(posedge ref_clk);
  endtask : cmd
  task automatic setp(input word_t s, input word_t t, input word_t r, input word_t p);
    wr(`OFS_START_SPD, s);
    wr(`OFS_TARGET_SPD, t);
    wr(`OFS_RAMP_MS, r);
    wr(`OFS_POS_CMD, p);
  endtask : setp
  task automatic wait_sig(input logic v, input logic pulse_minus, input logic on_pulse);
    int n;
    n = 0;
    do
    begin
      @(posedge ref_clk);
      n++;
    end
    while ((on_pulse ? (pulse_minus ? ccw_out : cw_out) : busy_out) !== v && n < 20000);
    if (n >= 20000) check_bit(1'b0, 1'b1);
  endtask : wait_sig
  function automatic word_t lfsr_next();
    lfsr = {lfsr[30:0], 1'b0} ^ (lfsr[31] ? 32'h04c1_1db7 : 32'h0);
    return lfsr;
  endfunction : lfsr_next
  function automatic word_t stat(input int b, input int d, input int se, input int le, input int dir);
    return word_t'(b + 2 * d + 4 * se + 8 * le + 16 * dir);
  endfunction : stat
  task automatic test_done();
    $display("comparisons %0d, mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : test_done
  // ----------------------------------------
  // watchdog
  // ----------------------------------------
  initial
  begin
    #(100 * 90000);
    err_count++;
    $display("unexpected at %0t: run hung", $time);
    test_done();
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    repeat (20) @(posedge ref_clk);
    reset <= 1'b0;
    rchk(`OFS_CTRL, `CTRL_RST, '1);
    rchk(`OFS_BASE_WORD, `BASE_WORD_RST, '1);
    rchk(`OFS_STATUS, 32'h0, 32'h3f);
    rchk(8'h40, 32'h0, '1, `RESP_SLVERR);
    wr(8'h40, 32'hffff_ffff, `RESP_SLVERR);
    wr(`OFS_RAMP_MS, `MAX_RAMP_MS);
    rchk(`OFS_RAMP_MS, `MAX_RAMP_MS, '1);
    wr(`OFS_POS_CMD, 32'h8000_0000);
    rchk(`OFS_POS_CMD, 32'h8000_0000, '1);
    $display("test reset_regs done");
    // default logic: low input is an active limit
    setp(32'h182b8, 32'h186a0, 32'h0, 32'd20);
    limit_neg_in <= 1'b0;
    cmd(`CMD_START);
    rchk(`OFS_STATUS, stat(0, 0, 0, 1, 0), 32'h0f);
    // all refusal codes set inverted logic, so low inputs mean no limit
    limit_pos_in <= 1'b0;
    cmd(`CMD_ERRCLR);
    for (int i = 0; i < 5; i++)
    begin
      wr(`OFS_CTRL, bad[i][0]);
      setp(bad[i][1], bad[i][2], bad[i][3], 32'd20);
      cmd(`CMD_START);
      rchk(`OFS_STATUS, stat(0, 0, 1, 0, 0), 32'h0f);
      cmd(`CMD_ERRCLR);
    end
    $display("test start_refusals done");
    for (int k = 0; k < 2; k++)
    begin
      mag = int'(lfsr_next() % 16) + 1;
      setp(32'h182b8, 32'h186a0, 32'h0, k ? word_t'(-mag) : word_t'(mag));
      cmd(`CMD_START);
      check_bit(busy_out, 1'b1);
      cmd(`CMD_START);
      cmd(`CMD_PULSER);
      rchk(`OFS_STATUS, stat(1, 0, 0, 0, 0), 32'h0f);
      repeat (300) @(posedge ref_clk);
      check_bit((k ? ccw_count : cw_count) > 0, 1'b1);
      rchk(`OFS_COUNT, 32'h0, '1);
      wait_sig(1'b1, k[0], 1'b1);
      // let the driver count the pulse just seen before the baseline is taken
      @(posedge ref_clk);
      c0 = cw_count;
      c1 = ccw_count;
      if (k == 0) timing_in <= 1'b1;
      else cmd(`CMD_TRIG);
      wait_sig(1'b0, 1'b0, 1'b0);
      timing_in <= 1'b0;
      check_reg(word_t'(k ? ccw_count - c1 : cw_count - c0), word_t'(mag), '1);
      check_reg(word_t'(k ? cw_count - c0 : ccw_count - c1), 32'h0, '1);
      check_bit(done_out, 1'b1);
      rchk(`OFS_COUNT, word_t'(mag), '1);
      rchk(`OFS_STATUS, stat(0, 1, 0, 0, k), 32'h1f);
    end
    cmd(`CMD_PULSER);
    check_bit(done_out, 1'b0);
    check_bit(busy_out, 1'b0);
    $display("test relative_moves done");
    for (int s = 0; s < 3; s++)
    begin
      setp(32'h182b8, 32'h186a0, 32'h0, 32'd1000);
      cmd(`CMD_START);
      repeat (200) @(posedge ref_clk);
      if (s == 2) limit_pos_in <= 1'b1;
      else cmd(s ? `CMD_DSTOP : `CMD_FSTOP);
      wait_sig(1'b0, 1'b0, 1'b0);
      check_bit(done_out, 1'b1);
      rchk(`OFS_STATUS, stat(0, 1, 0, s == 2, 0), 32'h0f);
      limit_pos_in <= 1'b0;
      cmd(`CMD_ERRCLR);
    end
    $display("test stops done");
    test_done();
  end
endmodule : tb_top
